// ==== design/eiv_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module eiv_ctrl
  import eiv_pkg::*;
#(
  parameter int unsigned LOW_W = PC_LOW_W,
  parameter int unsigned HIGH_W = PC_HIGH_W
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic ext_irq_pin_in,
  input wire logic [LOW_W+HIGH_W-1:0] pin_change_lines_in,
  input wire logic [LOW_W-1:0] pin_change_mask_low_in,
  input wire logic [HIGH_W-1:0] pin_change_mask_high_in,
  input wire logic sense_select_hi_in,
  input wire logic sense_select_lo_in,
  input wire logic ext_irq_en_in,
  input wire logic pc_low_en_in,
  input wire logic pc_high_en_in,
  input wire logic global_irq_en_in,
  input wire eiv_flags_s flag_clear_in,
  input wire logic [NUM_OTHER-1:0] other_irq_req_in,
  input wire logic vec_ack_in,
  input wire logic sleep_in,
  input wire logic sleep_idle_in,
  output logic irq_req_out,
  output logic [VEC_W-1:0] irq_vector_out,
  output var eiv_flags_s flags_out,
  output logic wake_out
);

  // The vector logic is written for exactly these group widths
  if (LOW_W != PC_LOW_W || HIGH_W != PC_HIGH_W) begin : g_chk
    $error("eiv_ctrl: pin-change group widths unsupported");
  end

  localparam int unsigned NPC = LOW_W + HIGH_W;

  // Checks run on the one clock and stay quiet in reset
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  // Previous samples of the pins
  logic ext_pin_q;
  logic [NPC-1:0] pc_pin_q;
  // Request flags
  eiv_flags_s flags_q, flags_d;
  // Presented request and vector
  logic irq_req_q, irq_req_d;
  logic [VEC_W-1:0] vec_q, vec_d;
  // Wake-up indication
  logic wake_q, wake_d;

  // Decoded sense mode
  eiv_sense_e sense;
  // I/O clock presence
  logic io_run;
  // Per-line toggle, masked per group
  logic [NPC-1:0] pc_toggle;
  logic [NPC-1:0] pc_mask;
  logic pcl_evt, pch_evt;
  // Dedicated pin events
  logic ext_fall, ext_rise, ext_evt;
  logic lvl_req;
  // Served-flag clears from the core
  eiv_flags_s ack_clr;
  // Pending requests by vector number
  logic [NUM_VEC-1:0] pend_d;

  assign sense = eiv_sense_e'({sense_select_hi_in, sense_select_lo_in});

  // I/O clock gating
  // Halted in every sleep mode except Idle
  assign io_run = !sleep_in || sleep_idle_in;

  assign pc_mask = {pin_change_mask_high_in, pin_change_mask_low_in};

  // Per-line toggle detection, one entry per line
  for (genvar i = 0; i < NPC; i++) begin : g_pc
    assign pc_toggle[i] = (pin_change_lines_in[i] ^ pc_pin_q[i]) & pc_mask[i];
  end

  assign pcl_evt = |pc_toggle[LOW_W-1:0];
  assign pch_evt = |pc_toggle[NPC-1:LOW_W];

  assign ext_fall = io_run && ext_pin_q && !ext_irq_pin_in;
  assign ext_rise = io_run && !ext_pin_q && ext_irq_pin_in;

  // Edge event per sense mode
  always_comb begin
    ext_evt = 1'b0;
    case (sense)
      EIV_SNS_ANY: ext_evt = ext_fall || ext_rise;
      EIV_SNS_FALL: ext_evt = ext_fall;
      EIV_SNS_RISE: ext_evt = ext_rise;
      default: ext_evt = 1'b0;
    endcase
  end

  // a level that ended before start-up never reaches here
  assign lvl_req = (sense == EIV_SNS_LOW) && !ext_irq_pin_in && ext_irq_en_in;

  // Pin sampling; direction of the pin is irrelevant
  // Reset samples equal the idle pin levels, so no false edge after reset
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_pin_q <= 1'b1;
      pc_pin_q <= '0;
    end else begin
      ext_pin_q <= ext_irq_pin_in;
      pc_pin_q <= pin_change_lines_in;
    end
  end

  // Handler entry clears the served flag
  always_comb begin
    ack_clr = FLAGS_RST;
    if (vec_ack_in && irq_req_q) begin
      ack_clr.ext = (vec_q == VEC_EXT);
      ack_clr.pcl = (vec_q == VEC_PC_LOW);
      ack_clr.pch = (vec_q == VEC_PC_HIGH);
    end
  end

  // Flag next state; a new event beats a clear in the same cycle
  always_comb begin
    flags_d.ext = (flags_q.ext && !flag_clear_in.ext && !ack_clr.ext) || ext_evt;
    flags_d.pcl = (flags_q.pcl && !flag_clear_in.pcl && !ack_clr.pcl) || pcl_evt;
    flags_d.pch = (flags_q.pch && !flag_clear_in.pch && !ack_clr.pch) || pch_evt;
    if (sense == EIV_SNS_LOW) begin
      flags_d.ext = 1'b0;
    end
  end

  // Pending requests, built from the next flags so the
  // presented request never lags a clear by a cycle
  always_comb begin
    pend_d = '0;
    if (global_irq_en_in) begin
      pend_d[VEC_EXT] = (flags_d.ext && ext_irq_en_in) || lvl_req;
      pend_d[VEC_PC_LOW] = flags_d.pcl && pc_low_en_in;
      pend_d[VEC_PC_HIGH] = flags_d.pch && pc_high_en_in;
      pend_d[VEC_LAST:VEC_FIRST_OTHER] = other_irq_req_in;
    end
  end

  // Priority encoder; vector zero is reset and never requested
  always_comb begin
    vec_d = VEC_RST_VAL;
    irq_req_d = 1'b0;
    for (int v = NUM_VEC - 1; v >= 1; v--) begin
      if (pend_d[v]) begin
        vec_d = VEC_W'(v);
        irq_req_d = 1'b1;
      end
    end
  end

  // Wake-up needs no I/O clock for level or pin change
  always_comb begin
    wake_d = 1'b0;
    if (sleep_in) begin
      wake_d = lvl_req || (pcl_evt && pc_low_en_in) || (pch_evt && pc_high_en_in);
      // Edges only in Idle, where the I/O clock still runs
      if (ext_evt && ext_irq_en_in) begin
        wake_d = 1'b1;
      end
    end
  end

  // Registered state
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_q <= FLAGS_RST;
      irq_req_q <= 1'b0;
      vec_q <= VEC_RST_VAL;
      wake_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      irq_req_q <= irq_req_d;
      vec_q <= vec_d;
      wake_q <= wake_d;
    end
  end

  // Outputs straight from flip-flops
  assign irq_req_out = irq_req_q;
  assign irq_vector_out = vec_q;
  assign flags_out = flags_q;
  assign wake_out = wake_q;

  // Checks

  sequence s_ack_high;
    irq_req_q && vec_q == VEC_PC_HIGH && vec_ack_in;
  endsequence

  sequence s_no_high_evt;
    !pch_evt && !flag_clear_in.pch;
  endsequence

  sequence s_fall_seen;
    global_irq_en_in && ext_irq_en_in && sense == EIV_SNS_FALL && ext_fall;
  endsequence

  fall_to_vec_a: assert property (s_fall_seen |=> irq_req_q && vec_q == 5'h01)
    else $error("falling edge not dispatched to vector one");

  low_vec_a: assert property (irq_req_q && vec_q == VEC_PC_LOW |-> flags_q.pcl)
    else $error("low group vector without its flag");

  high_vec_a: assert property (irq_req_q && vec_q == VEC_PC_HIGH |-> flags_q.pch)
    else $error("high group vector without its flag");

  timer_vec_a: assert property (pend_d[6:1] == 6'h20 |=> vec_q == 5'h06)
    else $error("timer compare request misplaced");

  never_reset_a: assert property (irq_req_q |-> vec_q != 5'h00 && $past(global_irq_en_in))
    else $error("reset vector or disabled source fetched");

  low_toggle_a: assert property (pcl_evt |=> flags_q.pcl)
    else $error("low group toggle missed");

  high_toggle_a: assert property (pch_evt |=> flags_q.pch)
    else $error("high group toggle missed");

  // Toggle of an unmasked low line, rebuilt from the pins and the mask port
  logic [LOW_W-1:0] low_seen;
  assign low_seen = (pin_change_lines_in[LOW_W-1:0] ^ pc_pin_q[LOW_W-1:0]) & pin_change_mask_low_in;

  mask_off_a: assert property (!flags_q.pcl && ~|low_seen |=> !flags_q.pcl)
    else $error("masked line raised low group flag");

  level_hold_a: assert property (global_irq_en_in && lvl_req |=> irq_req_q && vec_q == 5'h01)
    else $error("held low level not requesting");

  no_clk_edge_a: assert property (sleep_in && !sleep_idle_in && !flags_q.ext |=> !flags_q.ext)
    else $error("edge flagged without I/O clock");

  level_wake_a: assert property (sleep_in && lvl_req |=> wake_q)
    else $error("low level did not wake");

  ack_clear_a: assert property (s_ack_high ##0 s_no_high_evt |=> !flags_q.pch)
    else $error("handler entry left flag set");

  level_flag_a: assert property (sense == EIV_SNS_LOW |=> !flags_q.ext)
    else $error("flag set in level mode");

  first_wins_a: assert property (pend_d[1] |=> vec_q == 5'h01 && irq_req_q)
    else $error("lower vector not served first");

  edge_flag_a: assert property (io_run && sense == EIV_SNS_FALL && $fell(ext_irq_pin_in) |=> flags_q.ext)
    else $error("falling pin edge not flagged");

  vec_range_a: assert property (irq_req_q |-> vec_q <= VEC_LAST)
    else $error("vector beyond the last address");

  timer0_vec_a: assert property (pend_d[9:1] == 9'h100 |=> vec_q == VEC_T0_COMPA)
    else $error("second timer compare request misplaced");

endmodule
`default_nettype wire

// ==== inc/eiv_pkg.sv ====
`default_nettype none
package eiv_pkg;
  // Vector address width and vector count
  localparam int unsigned VEC_W = 5;
  localparam int unsigned NUM_VEC = 17;
  // Sources other than reset and the three pin requests
  localparam int unsigned NUM_OTHER = 13;
  // Pin-change group widths
  localparam int unsigned PC_LOW_W = 8;
  localparam int unsigned PC_HIGH_W = 4;
  // Program addresses of the vectors this block names
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_EXT = 5'h01;
  localparam logic [4:0] VEC_PC_LOW = 5'h02;
  localparam logic [4:0] VEC_PC_HIGH = 5'h03;
  localparam logic [4:0] VEC_FIRST_OTHER = 5'h04;
  localparam logic [4:0] VEC_T1_COMPA = 5'h06;
  localparam logic [4:0] VEC_T0_COMPA = 5'h09;
  localparam logic [4:0] VEC_LAST = 5'h10;
  // Bit positions of the flag struct
  localparam int unsigned FLAG_EXT = 0;
  localparam int unsigned FLAG_PCL = 1;
  localparam int unsigned FLAG_PCH = 2;
  // Sense-control encoding
  typedef enum logic [1:0] {
    EIV_SNS_LOW = 2'h0,
    EIV_SNS_ANY = 2'h1,
    EIV_SNS_FALL = 2'h2,
    EIV_SNS_RISE = 2'h3
  } eiv_sense_e;
  // Request flags, also used for write-one-to-clear
  typedef struct packed {
    logic pch;
    logic pcl;
    logic ext;
  } eiv_flags_s;
  localparam eiv_flags_s FLAGS_RST = 3'h0;
  localparam logic [4:0] VEC_RST_VAL = 5'h00;
endpackage
`default_nettype wire

// ==== verif/eiv_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Core side: enters the handler of whatever vector is shown
module eiv_core_model (
  input wire logic clk_in,
  input wire logic ack_en_in,
  input wire logic irq_req_in,
  output logic vec_ack_out
);
  initial vec_ack_out = 1'b0;
  // handler entry clears
  // Single-cycle pulse, so one entry per request
  always @(negedge clk_in) begin
    vec_ack_out <= ack_en_in && irq_req_in && !vec_ack_out;
  end
endmodule
`default_nettype wire

// ==== verif/test_ext_irq_and_vector_logic.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_ext_irq_and_vector_logic;
  import eiv_pkg::*;
  // Pin and line levels match the design's reset samples
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin = 1'b1;
  logic [11:0] lines = 12'h000;
  logic [7:0] mlo = 8'h00;
  logic [3:0] mhi = 4'h0;
  logic [1:0] sense = 2'h0;
  logic ext_en = 1'b0, pcl_en = 1'b0, pch_en = 1'b0, gen = 1'b0;
  eiv_flags_s clr = FLAGS_RST;
  logic [12:0] oth = 13'h0000;
  logic ack_en = 1'b0, slp = 1'b0, idle = 1'b0;
  logic ack, req, wake;
  logic [4:0] vec;
  eiv_flags_s flg;
  int err_total = 0;
  int n_checks = 0;
  // 125 MHz
  always #4 clk = ~clk;
  eiv_ctrl dut (.ref_clk_in(clk), .reset_n_in(rst_n), .ext_irq_pin_in(pin),
    .pin_change_lines_in(lines), .pin_change_mask_low_in(mlo), .pin_change_mask_high_in(mhi),
    .sense_select_hi_in(sense[1]), .sense_select_lo_in(sense[0]), .ext_irq_en_in(ext_en),
    .pc_low_en_in(pcl_en), .pc_high_en_in(pch_en), .global_irq_en_in(gen), .flag_clear_in(clr),
    .other_irq_req_in(oth), .vec_ack_in(ack), .sleep_in(slp), .sleep_idle_in(idle),
    .irq_req_out(req), .irq_vector_out(vec), .flags_out(flg), .wake_out(wake));
  eiv_core_model core (.clk_in(clk), .ack_en_in(ack_en), .irq_req_in(req), .vec_ack_out(ack));
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request, vector and flags in one go
  task automatic look(input logic r, input logic [4:0] v, input logic [2:0] f);
    chk("irq_req", {4'h0, r}, {4'h0, req});
    chk("vector", v, vec);
    chk("flags", {2'h0, f}, {2'h0, flg});
  endtask
  task automatic tick();
    @(negedge clk);
  endtask
  // One-cycle write-one-to-clear pulse
  task automatic clear(input logic [2:0] f);
    clr = f;
    tick();
    clr = FLAGS_RST;
  endtask
  task automatic s_level();
    sense = 2'h0;
    gen = 1'b1;
    ext_en = 1'b1;
    pin = 1'b0;
    tick();
    look(1'b1, VEC_EXT, 3'h0);
    repeat (3) tick();
    look(1'b1, VEC_EXT, 3'h0);
    pin = 1'b1;
    tick();
    look(1'b0, 5'h00, 3'h0);
  endtask
  // Any change, falling, rising: fall then rise in each
  task automatic s_edges();
    logic f;
    logic r;
    for (int s = 1; s < 4; s++) begin
      sense = s[1:0];
      tick();
      f = (s != 3);
      r = (s != 2);
      pin = 1'b0;
      tick();
      look(f, f ? VEC_EXT : 5'h00, {2'h0, f});
      clear(3'h1);
      pin = 1'b1;
      tick();
      look(r, r ? VEC_EXT : 5'h00, {2'h0, r});
      clear(3'h1);
    end
  endtask
  task automatic s_pc();
    ext_en = 1'b0;
    mlo = 8'h01;
    mhi = 4'h8;
    pcl_en = 1'b1;
    pch_en = 1'b1;
    ack_en = 1'b1;
    lines[1] = 1'b1;
    tick();
    look(1'b0, 5'h00, 3'h0);
    lines[0] = 1'b1;
    tick();
    look(1'b1, VEC_PC_LOW, 3'h2);
    tick();
    look(1'b0, 5'h00, 3'h0);
    ack_en = 1'b0;
    lines[11] = 1'b1;
    tick();
    look(1'b1, VEC_PC_HIGH, 3'h4);
    lines[0] = 1'b0;
    tick();
    look(1'b1, VEC_PC_LOW, 3'h6);
    pcl_en = 1'b0;
    clear(3'h6);
    lines[0] = 1'b1;
    tick();
    look(1'b0, 5'h00, 3'h2);
    clear(3'h2);
    // Handler entry of the high group clears its flag
    ack_en = 1'b1;
    lines[11] = 1'b0;
    tick();
    look(1'b1, VEC_PC_HIGH, 3'h4);
    tick();
    look(1'b0, 5'h00, 3'h0);
    ack_en = 1'b0;
  endtask
  task automatic s_prio();
    oth = 13'h0024;
    tick();
    look(1'b1, VEC_T1_COMPA, 3'h0);
    oth = 13'h0020;
    tick();
    look(1'b1, VEC_T0_COMPA, 3'h0);
    oth = 13'h1000;
    tick();
    look(1'b1, VEC_LAST, 3'h0);
    gen = 1'b0;
    tick();
    look(1'b0, 5'h00, 3'h0);
    oth = 13'h0000;
    gen = 1'b1;
  endtask
  // Deep sleep: edges lost, toggles and low level still wake
  task automatic s_sleep();
    slp = 1'b1;
    sense = 2'h2;
    ext_en = 1'b1;
    pcl_en = 1'b1;
    pin = 1'b0;
    tick();
    look(1'b0, 5'h00, 3'h0);
    chk("wake", 5'h00, {4'h0, wake});
    pin = 1'b1;
    tick();
    lines[0] = 1'b0;
    tick();
    chk("wake", 5'h01, {4'h0, wake});
    sense = 2'h0;
    clear(3'h2);
    chk("wake", 5'h00, {4'h0, wake});
    pin = 1'b0;
    tick();
    chk("wake", 5'h01, {4'h0, wake});
    look(1'b1, VEC_EXT, 3'h0);
    sense = 2'h2;
    pin = 1'b1;
    idle = 1'b1;
    tick();
    pin = 1'b0;
    tick();
    look(1'b1, VEC_EXT, 3'h1);
    clear(3'h1);
    slp = 1'b0;
  endtask
  initial begin
    repeat (2) tick();
    rst_n = 1'b1;
    tick();
    look(1'b0, VEC_RST_VAL, FLAGS_RST);
    s_level();
    s_edges();
    s_pc();
    s_prio();
    s_sleep();
    final_report();
  end
  // Whole run is about 45 cycles
  initial begin
    #20000;
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
